// ===== design/flash_bus_cycle.sv
// One timed write or read cycle on the flash parallel pins.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_bus_cycle
   import flash_host_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic start,
   input wire flash_host_pkg::cycle_s cyc,
   input wire logic [7:0] dq_in,
   output flash_host_pkg::pins_s pins,
   output logic done,
   output logic [7:0] rd_data
);
   import flash_host_pkg::*;
   localparam logic [3:0] STROBE_N = 4'(`STROBE_CYC);
   localparam logic [3:0] GAP_N = 4'(`GAP_CYC);
   logic [1:0] ph_r, ph_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   pins_s pins_r, pins_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic done_nxt, done_r;
   always_comb
   begin
      ph_nxt = ph_r;
      cnt_nxt = cnt_r;
      pins_nxt = pins_r;
      rd_nxt = rd_r;
      done_nxt = 1'b0;
      case (ph_r)
         2'd0:
         begin
            if (start)
            begin
               pins_nxt.addr = cyc.addr;
               pins_nxt.dq_out = cyc.data;
               pins_nxt.dq_oe = cyc.we;
               pins_nxt.ce_n = 1'b0;
               pins_nxt.we_n = ~cyc.we;
               pins_nxt.oe_n = cyc.we;
               cnt_nxt = STROBE_N;
               ph_nxt = 2'd1;
            end
         end
         2'd1:
         begin
            if (cnt_r > 4'h1)
               cnt_nxt = cnt_r - 4'h1;
            else
            begin
               // Data is sampled before the strobe rises; the rising edge starts the gap phase, and done follows after the gap.
               rd_nxt = dq_in;
               pins_nxt.ce_n = 1'b1;
               pins_nxt.we_n = 1'b1;
               pins_nxt.oe_n = 1'b1;
               cnt_nxt = GAP_N;
               ph_nxt = 2'd2;
            end
         end
         2'd2:
         begin
            pins_nxt.dq_oe = 1'b0;
            if (cnt_r > 4'h1)
               cnt_nxt = cnt_r - 4'h1;
            else
            begin
               done_nxt = 1'b1;
               ph_nxt = 2'd0;
            end
         end
         default: ph_nxt = 2'd0;
      endcase
   end
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ph_r <= 2'd0;
         cnt_r <= 4'h0;
         pins_r <= '{addr: '0, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
         rd_r <= 8'h00;
         done_r <= 1'b0;
      end
      else if (ce)
      begin
         ph_r <= ph_nxt;
         cnt_r <= cnt_nxt;
         pins_r <= pins_nxt;
         rd_r <= rd_nxt;
         done_r <= done_nxt;
      end
   end
   assign pins = pins_r;
   assign rd_data = rd_r;
   assign done = done_r & ce;
endmodule

// ===== design/flash_host_params.svh
// Constants for the flash status-polling host controller.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH
`define CLK_MHZ 200
`define ADDR_W 21
`define SEC_LSB 13
// Software register offsets.
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_STAT 4'h3
`define REG_RDATA 4'h4
// Control register field positions.
`define CTRL_GO 0
`define CTRL_OP_LSB 1
`define CTRL_POLL_TOGGLE 4
`define CTRL_BYPASS 5
// Status register field positions.
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_BYPASS 3
`define ST_RDY 4
// Command bytes and unlock addresses.
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_RESET 8'hF0
`define CMD_AUTOSEL 8'h90
`define CMD_PROG 8'hA0
`define CMD_BYPASS 8'h20
`define CMD_ERASE 8'h80
`define CMD_CHIP 8'h10
`define CMD_SECT 8'h30
`define CMD_SUSP 8'hB0
`define CMD_RESUME 8'h30
`define CMD_BYP_EXIT2 8'h00
`define ADR_U1 21'h00_0555
`define ADR_U2 21'h00_02AA
`define ADR_SECPROT 21'h00_0002
// Bus cycle timing: strobe low time and gap, in ns.
`define T_STROBE_NS 60
`define T_GAP_NS 40
`define STROBE_CYC ((`T_STROBE_NS * `CLK_MHZ + 999) / 1000)
`define GAP_CYC ((`T_GAP_NS * `CLK_MHZ + 999) / 1000)
`endif

// ===== design/flash_host_pkg.sv
// Types for the flash status-polling host controller.
package flash_host_pkg;
   typedef enum logic [2:0]
   {
      OP_READ = 3'h0,
      OP_PROG = 3'h1,
      OP_SECT_ERASE = 3'h2,
      OP_CHIP_ERASE = 3'h3,
      OP_RESET = 3'h4,
      OP_SUSPEND = 3'h5,
      OP_RESUME = 3'h6,
      OP_PROT_QUERY = 3'h7
   } op_e;
   typedef struct packed
   {
      logic [20:0] addr;
      logic [7:0] data;
      logic we;
   } cycle_s;
   typedef struct packed
   {
      logic [20:0] addr;
      logic [7:0] dq_out;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
   } pins_s;
endpackage

// ===== design/flash_poll_host.sv
// Host controller that issues flash commands and polls write status.
`timescale 1ns/1ps
`include "flash_host_params.svh"
// Behaviour
// - Leave identification mode or timing failure by writing the reset command.
// - Identification sequence: three writes, then a fourth read cycle.
// - Bypass program short form only after unlock bypass entry; here the control bypass bit sets the flag with no entry cycles.
// - Bypass mode left only by the bypass reset command.
// - Program poll reads at the program address; bit 7 inverted until done.
// - Erase poll reads inside a selected sector; bit 7 zero until done.
// - After bit 7 turns true, valid data comes from the next read.
// - Toggle check: two consecutive reads; unchanged means complete.
// - Toggling with bit 5 high: recheck, still toggling means reset and fail.
// - Toggle check restarts with a double read after leaving polling.
// - Data polling rereads bit 7 after seeing bit 5 high.
module flash_poll_host
   import flash_host_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [20:0] flash_addr,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   input wire logic ready_busy_n_in
);
   import flash_host_pkg::*;
   typedef enum logic [3:0]
   {
      S_IDLE = 4'b0000,
      S_SEQ = 4'b0001,
      S_POLL1 = 4'b0011,
      S_POLL2 = 4'b0010,
      S_RECHK1 = 4'b0110,
      S_RECHK2 = 4'b0111,
      S_FINAL = 4'b0101,
      S_RESET = 4'b0100,
      S_END = 4'b1100
   } state_e;
   state_e st_r, st_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [2:0] op_r, op_nxt;
   logic [20:0] addr_r, addr_nxt;
   logic [7:0] data_r, data_nxt;
   logic tog_mode_r, tog_mode_nxt;
   logic bypass_r, bypass_nxt;
   logic done_r, done_nxt, fail_r, fail_nxt;
   logic [7:0] first_r, first_nxt, rdata_r, rdata_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic issue;
   cycle_s cyc;
   logic [2:0] seq_len;
   logic cyc_done;
   logic [7:0] cyc_rd;
   pins_s pins;
   logic busy;
   logic rdy_s;
   op_e op;
   assign op = op_e'(op_r);
   assign busy = (st_r != S_IDLE);
   // Ready/busy is open drain and pulled up; host only observes it.
   assign rdy_s = ready_busy_n_in;
   // Length of each command sequence; only the read and protection query end with a read cycle.
   always_comb
   begin
      case (op)
         OP_READ: seq_len = 3'd1;
         OP_PROG: seq_len = bypass_r ? 3'd2 : 3'd4;
         OP_SECT_ERASE: seq_len = 3'd6;
         OP_CHIP_ERASE: seq_len = 3'd6;
         OP_RESET: seq_len = bypass_r ? 3'd2 : 3'd1;
         OP_SUSPEND: seq_len = 3'd1;
         OP_RESUME: seq_len = 3'd1;
         OP_PROT_QUERY: seq_len = 3'd4;
         default: seq_len = 3'd1;
      endcase
   end
   // Bus cycle table; unlock cycles drive only low address bits, upper bits zero.
   always_comb
   begin
      cyc = '{addr: `ADR_U1, data: `CMD_UNLOCK1, we: 1'b1};
      case (op)
         OP_READ: cyc = '{addr: addr_r, data: 8'h00, we: 1'b0};
         OP_PROG:
            if (bypass_r)
               cyc = (idx_r == 3'd0) ? '{addr: `ADR_U1, data: `CMD_PROG, we: 1'b1}
                                     : '{addr: addr_r, data: data_r, we: 1'b1};
            else if (idx_r == 3'd1)
               cyc = '{addr: `ADR_U2, data: `CMD_UNLOCK2, we: 1'b1};
            else if (idx_r == 3'd2)
               cyc = '{addr: `ADR_U1, data: `CMD_PROG, we: 1'b1};
            else if (idx_r == 3'd3)
               cyc = '{addr: addr_r, data: data_r, we: 1'b1};
         OP_SECT_ERASE, OP_CHIP_ERASE:
            case (idx_r)
               3'd1, 3'd4: cyc = '{addr: `ADR_U2, data: `CMD_UNLOCK2, we: 1'b1};
               3'd2: cyc = '{addr: `ADR_U1, data: `CMD_ERASE, we: 1'b1};
               3'd5:
                  cyc = (op == OP_CHIP_ERASE) ? '{addr: `ADR_U1, data: `CMD_CHIP, we: 1'b1}
                                              : '{addr: addr_r, data: `CMD_SECT, we: 1'b1};
               default: cyc = '{addr: `ADR_U1, data: `CMD_UNLOCK1, we: 1'b1};
            endcase
         OP_RESET:
            if (bypass_r)
               cyc = (idx_r == 3'd0) ? '{addr: '0, data: `CMD_AUTOSEL, we: 1'b1}
                                     : '{addr: '0, data: `CMD_BYP_EXIT2, we: 1'b1};
            else
               cyc = '{addr: '0, data: `CMD_RESET, we: 1'b1};
         OP_SUSPEND: cyc = '{addr: '0, data: `CMD_SUSP, we: 1'b1};
         OP_RESUME: cyc = '{addr: '0, data: `CMD_RESUME, we: 1'b1};
         OP_PROT_QUERY:
            case (idx_r)
               3'd1: cyc = '{addr: `ADR_U2, data: `CMD_UNLOCK2, we: 1'b1};
               3'd2: cyc = '{addr: `ADR_U1, data: `CMD_AUTOSEL, we: 1'b1};
               3'd3: cyc = '{addr: {addr_r[20:`SEC_LSB], 13'h0002}, data: 8'h00, we: 1'b0};
               default: cyc = '{addr: `ADR_U1, data: `CMD_UNLOCK1, we: 1'b1};
            endcase
         default: cyc = '{addr: `ADR_U1, data: `CMD_UNLOCK1, we: 1'b1};
      endcase
      // Status polls read at the target: program address or selected sector.
      if (st_r != S_SEQ && st_r != S_RESET)
         cyc = '{addr: addr_r, data: 8'h00, we: 1'b0};
      if (st_r == S_RESET)
         cyc = '{addr: '0, data: `CMD_RESET, we: 1'b1};
   end
   flash_bus_cycle u_cycle
   (
      .mclk(mclk),
      .srst(srst),
      .ce(clk_en),
      .start(issue),
      .cyc(cyc),
      .dq_in(flash_dq_in),
      .pins(pins),
      .done(cyc_done),
      .rd_data(cyc_rd)
   );
   logic launched_r, launched_nxt;
   assign issue = busy && !launched_r && st_r != S_END;
   // Sequencer and polling state.
   always_comb
   begin
      st_nxt = st_r;
      idx_nxt = idx_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      tog_mode_nxt = tog_mode_r;
      bypass_nxt = bypass_r;
      done_nxt = done_r;
      fail_nxt = fail_r;
      first_nxt = first_r;
      rdata_nxt = rdata_r;
      launched_nxt = launched_r;
      if (issue)
         launched_nxt = 1'b1;
      if (cyc_done)
         launched_nxt = 1'b0;
      if (reg_wr && reg_addr == `REG_ADDR && !busy)
         addr_nxt = reg_wdata[20:0];
      if (reg_wr && reg_addr == `REG_DATA && !busy)
         data_nxt = reg_wdata[7:0];
      case (st_r)
         S_IDLE:
            if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_GO])
            begin
               op_nxt = reg_wdata[`CTRL_OP_LSB +: 3];
               tog_mode_nxt = reg_wdata[`CTRL_POLL_TOGGLE];
               if (reg_wdata[`CTRL_BYPASS] && !bypass_r)
                  bypass_nxt = 1'b1;
               idx_nxt = 3'd0;
               done_nxt = 1'b0;
               fail_nxt = 1'b0;
               // Entry to bypass issues no cycles of its own; the flag is set and the operation starts at idx 0.
               st_nxt = (reg_wdata[`CTRL_BYPASS] && !bypass_r) ? S_SEQ : S_SEQ;
            end
         S_SEQ:
            if (cyc_done)
            begin
               if (idx_r == seq_len - 3'd1)
               begin
                  rdata_nxt = cyc_rd;
                  if (op == OP_RESET)
                     bypass_nxt = 1'b0;
                  // Polling starts only after the final write strobe has risen.
                  if (op == OP_PROG || op == OP_SECT_ERASE || op == OP_CHIP_ERASE)
                     st_nxt = S_POLL1;
                  else
                     st_nxt = S_END;
               end
               else
                  idx_nxt = idx_r + 3'd1;
            end
         S_POLL1:
            if (cyc_done)
            begin
               first_nxt = cyc_rd;
               if (!tog_mode_r && cyc_rd[7] == ((op == OP_PROG) ? data_r[7] : 1'b1))
                  st_nxt = S_FINAL;
               else if (!tog_mode_r && cyc_rd[5])
                  st_nxt = S_RECHK2;
               else if (tog_mode_r)
                  st_nxt = S_POLL2;
            end
         S_POLL2:
            if (cyc_done)
            begin
               if (cyc_rd[6] == first_r[6])
                  st_nxt = S_FINAL;
               else if (cyc_rd[5])
                  st_nxt = S_RECHK1;
               else
                  st_nxt = S_POLL1;
               first_nxt = cyc_rd;
            end
         S_RECHK1:
            if (cyc_done)
               st_nxt = (cyc_rd[6] == first_r[6]) ? S_FINAL : S_RESET;
         S_RECHK2:
            if (cyc_done)
               st_nxt = (cyc_rd[7] == ((op == OP_PROG) ? data_r[7] : 1'b1)) ? S_FINAL : S_RESET;
         S_FINAL:
            if (cyc_done)
            begin
               rdata_nxt = cyc_rd;
               done_nxt = 1'b1;
               st_nxt = S_END;
            end
         S_RESET:
            if (cyc_done)
            begin
               fail_nxt = 1'b1;
               st_nxt = S_END;
            end
         S_END:
         begin
            if (op != OP_PROG && op != OP_SECT_ERASE && op != OP_CHIP_ERASE)
               done_nxt = 1'b1;
            st_nxt = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end
   // Register read mux; data stands in the cycle after the strobe.
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      if (reg_rd)
         case (reg_addr)
            `REG_CTRL: rd_nxt = {26'h000_0000, bypass_r, tog_mode_r, op_r, 1'b0};
            `REG_ADDR: rd_nxt = {11'h000, addr_r};
            `REG_DATA: rd_nxt = {24'h00_0000, data_r};
            `REG_STAT: rd_nxt = {27'h000_0000, rdy_s, bypass_r, fail_r, done_r, busy};
            `REG_RDATA: rd_nxt = {24'h00_0000, rdata_r};
            default: rd_nxt = 32'h0000_0000;
         endcase
   end
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_r <= S_IDLE;
         idx_r <= 3'd0;
         op_r <= 3'd0;
         addr_r <= '0;
         data_r <= 8'h00;
         tog_mode_r <= 1'b0;
         bypass_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         first_r <= 8'h00;
         rdata_r <= 8'h00;
         rd_r <= 32'h0000_0000;
         launched_r <= 1'b0;
      end
      else if (clk_en)
      begin
         st_r <= st_nxt;
         idx_r <= idx_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         tog_mode_r <= tog_mode_nxt;
         bypass_r <= bypass_nxt;
         done_r <= done_nxt;
         fail_r <= fail_nxt;
         first_r <= first_nxt;
         rdata_r <= rdata_nxt;
         rd_r <= rd_nxt;
         launched_r <= launched_nxt;
      end
   end
   assign reg_rdata = rd_r;
   assign flash_addr = pins.addr;
   assign flash_dq_out = pins.dq_out;
   assign flash_dq_oe = pins.dq_oe;
   assign flash_ce_n = pins.ce_n;
   assign flash_oe_n = pins.oe_n;
   assign flash_we_n = pins.we_n;
   // A failed check always ends in a reset write before the fail flag.
   sequence reset_wr_s;
      (st_r == S_RESET) ##1 (st_r == S_RESET)[*1];
   endsequence
   reset_before_fail_a: assert property (@(posedge mclk) disable iff (srst)
      $rose(fail_r) |-> $past(st_r) == S_RESET)
      else $error("Fail flag set without a reset write.");
   poll_after_seq_a: assert property (@(posedge mclk) disable iff (srst)
      (st_r == S_POLL1 && $past(st_r) != S_POLL1) |-> $past(st_r) inside {S_SEQ, S_POLL2})
      else $error("Polling began outside a command sequence.");
   toggle_pair_a: assert property (@(posedge mclk) disable iff (srst)
      (st_r == S_POLL1 && tog_mode_r && cyc_done && clk_en) |=> st_r == S_POLL2)
      else $error("Toggle check did not take a second read.");
   bus_idle_a: assert property (@(posedge mclk) disable iff (srst)
      !(!flash_we_n && !flash_oe_n))
      else $error("Write and output strobes low together.");
   write_drives_a: assert property (@(posedge mclk) disable iff (srst)
      !flash_we_n |-> flash_dq_oe)
      else $error("Write strobe without driven data.");
   bypass_clear_a: assert property (@(posedge mclk) disable iff (srst)
      $fell(bypass_r) |-> $past(op_r) == 3'(OP_RESET))
      else $error("Bypass left without its reset command.");
   bypass_short_a: assert property (@(posedge mclk) disable iff (srst)
      (st_r == S_SEQ && op == OP_PROG && !bypass_r) |-> seq_len == 3'd4)
      else $error("Short program issued outside bypass.");
   recheck_fail_a: assert property (@(posedge mclk) disable iff (srst)
      (st_r == S_RECHK2 && cyc_done && clk_en && cyc_rd[7] != ((op == OP_PROG) ? data_r[7] : 1'b1))
      |=> st_r == S_RESET)
      else $error("Polling recheck did not lead to reset.");
endmodule

// ===== dv/flash_dev_model.sv
// Behavioural byte-wide flash device that answers the host controller on its parallel pins.
`timescale 1ns/1ps
module flash_dev_model
#(
   parameter int T_PROG_NS = 400,
   parameter int T_ERASE_NS = 4000,
   parameter int T_PPROG_NS = 1000,
   parameter int T_PERASE_NS = 100000,
   parameter logic [7:0] PROT_SEC = 8'h01
)
(
   input wire logic [20:0] addr,
   input wire logic [7:0] dq_in,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   output logic [7:0] dq_out,
   output logic rb_drive
);
   typedef enum logic [2:0] {M_ARRAY, M_AUTO, M_PROG, M_ERASE, M_SUSP} mode_e;
   mode_e mode = M_ARRAY;
   logic [7:0] mem [int];
   logic [7:0] q = 8'h00;
   logic [7:0] pd = 8'h00;
   logic [7:0] ld = 8'h00;
   logic [7:0] esec = 8'h00;
   logic [20:0] la = 21'h00_0000;
   logic [20:0] prog_addr = 21'h00_0000;
   logic e_all = 1'b0;
   logic t6 = 1'b0;
   logic t2 = 1'b0;
   logic tlf = 1'b0;
   int cyc = 0;
   int left_ns = 0;
   wire wr_act = !ce_n && !we_n;
   wire rd_act = !ce_n && !oe_n;
   function automatic logic [7:0] rd_mem(input logic [20:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
   endfunction
   function automatic logic prot(input logic [20:0] a);
      return a[20:13] == PROT_SEC;
   endfunction
   function automatic logic in_sel(input logic [20:0] a);
      return e_all || a[20:13] == esec;
   endfunction
   // The byte is fixed when the read opens, so each toggle bit moves at most once per read.
   always @(posedge rd_act)
   begin
      #1;
      if (mode == M_PROG)
      begin
         t6 = ~t6;
         q = {~pd[7], t6, tlf, 5'h00};
      end
      else if (mode == M_ERASE || (mode == M_SUSP && in_sel(addr)))
      begin
         t6 = (mode == M_ERASE) ? ~t6 : t6;
         t2 = in_sel(addr) ? ~t2 : t2;
         q = {mode == M_SUSP, t6, tlf, 1'b1, 1'b0, t2, 2'b00};
      end
      else if (mode == M_AUTO)
         q = (addr[7:0] == 8'h02) ? {7'h00, prot(addr)} : 8'h00;
      else
         q = rd_mem(addr);
   end
   // A bus the device does not drive shows the inverse of its last byte, never a stale copy.
   assign dq_out = rd_act ? q : ~q;
   assign rb_drive = mode == M_PROG || mode == M_ERASE;
   always @(posedge wr_act)
   begin
      #1;
      la = addr;
      ld = dq_in;
   end
   always @(negedge wr_act)
      do_write(la, ld);
   // Busy time runs in 10 ns steps and stands still while the erase is suspended.
   always #10
      if (left_ns > 0 && !tlf && mode != M_SUSP)
      begin
         left_ns = left_ns - 10;
         if (left_ns <= 0)
            finish_op();
      end
   task automatic finish_op();
      if (mode == M_ERASE)
         foreach (mem[k])
            if (!prot(k[20:0]) && in_sel(k[20:0]))
               mem[k] = 8'hFF;
      if (mode == M_PROG && !prot(prog_addr) && (rd_mem(prog_addr) & pd) != pd)
         tlf = 1'b1;
      else
      begin
         if (mode == M_PROG && !prot(prog_addr))
            mem[int'(prog_addr)] = pd;
         mode = M_ARRAY;
      end
   endtask
   task automatic do_write(input logic [20:0] a, input logic [7:0] d);
      logic u1;
      logic u2;
      u1 = a[10:0] == 11'h555;
      u2 = a[10:0] == 11'h2AA;
      if (d == 8'hF0 && (tlf || mode == M_AUTO))
      begin
         tlf = 1'b0;
         left_ns = 0;
         mode = M_ARRAY;
      end
      else if (mode == M_ERASE && d == 8'hB0)
         mode = M_SUSP;
      else if (mode == M_SUSP && d == 8'h30)
         mode = M_ERASE;
      else if (mode == M_ARRAY)
         case (cyc)
            0, 4: cyc = (u1 && d == 8'hAA) ? cyc + 1 : 0;
            1, 5: cyc = (u2 && d == 8'h55) ? cyc + 1 : 0;
            2:
            begin
               mode = (u1 && d == 8'h90) ? M_AUTO : M_ARRAY;
               cyc = !u1 ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
            end
            3:
            begin
               cyc = 0;
               prog_addr = a;
               pd = d;
               mode = M_PROG;
               left_ns = prot(a) ? T_PPROG_NS : T_PROG_NS;
            end
            default:
            begin
               cyc = 0;
               e_all = d == 8'h10;
               esec = a[20:13];
               mode = (e_all || d == 8'h30) ? M_ERASE : M_ARRAY;
               left_ns = (!e_all && prot(a)) ? T_PERASE_NS : T_ERASE_NS;
            end
         endcase
   endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench driving the host controller registers against a flash device model.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module tb_top;
   import flash_host_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] stat;
   logic [20:0] flash_addr;
   logic [7:0] flash_dq_out;
   logic [7:0] dev_dq;
   logic flash_dq_oe;
   logic flash_ce_n;
   logic flash_oe_n;
   logic flash_we_n;
   logic rb_drive;
   int num_errors = 0;
   int n_checks = 0;
   // The ready line has a pull-up, so it reads high unless the device sinks it.
   wire ready_line = !rb_drive;
   wire [7:0] dq_bus = flash_dq_oe ? flash_dq_out : dev_dq;
   always #2.5 mclk = ~mclk;
   flash_poll_host i_dut
   (
      .mclk(mclk),
      .srst(srst),
      .clk_en(1'b1),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out),
      .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(dq_bus),
      .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n),
      .ready_busy_n_in(ready_line)
   );
   // The all-protected erase is shortened from its nominal length to keep the run brief.
   flash_dev_model #(.T_PERASE_NS(20000)) i_dev
   (
      .addr(flash_addr),
      .dq_in(flash_dq_out),
      .ce_n(flash_ce_n),
      .oe_n(flash_oe_n),
      .we_n(flash_we_n),
      .dq_out(dev_dq),
      .rb_drive(rb_drive)
   );
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic start_op(input op_e op, input logic [20:0] a, input logic [7:0] d, input logic tog);
      reg_write(`REG_ADDR, {11'h000, a});
      reg_write(`REG_DATA, {24'h00_0000, d});
      reg_write(`REG_CTRL, {27'h000_0000, tog, op, 1'b1});
   endtask
   task automatic wait_done(input logic ef);
      for (int i = 0; i < 5000; i++)
      begin
         reg_read(`REG_STAT, stat);
         // A failed operation ends with the fail flag and no done flag.
         if ((stat[`ST_DONE] | stat[`ST_FAIL]) === 1'b1 && stat[`ST_BUSY] === 1'b0)
         begin
            check("fail_bit", {31'h0000_0000, ef}, {31'h0000_0000, stat[`ST_FAIL]});
            check("done_bit", {31'h0000_0000, !ef}, {31'h0000_0000, stat[`ST_DONE]});
            return;
         end
      end
      check("done_timeout", 32'h0000_0002, stat);
      finish_test();
   endtask
   task automatic run_op(input op_e op, input logic [20:0] a, input logic [7:0] d, input logic tog, input logic ef);
      start_op(op, a, d, tog);
      wait_done(ef);
   endtask
   task automatic rd_chk(input string nm, input op_e op, input logic [20:0] a, input logic [7:0] exp);
      logic [31:0] v;
      run_op(op, a, 8'h00, 1'b0, 1'b0);
      reg_read(`REG_RDATA, v);
      check(nm, {24'h00_0000, exp}, v);
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      reg_read(`REG_STAT, stat);
      check("stat_reset", 32'h0000_0010, stat);
      reg_read(4'h7, stat);
      check("unmapped_reg", 32'h0000_0000, stat);
      run_op(OP_PROG, 21'h00_4010, 8'h5A, 1'b0, 1'b0);
      run_op(OP_PROG, 21'h00_4011, 8'h3C, 1'b1, 1'b0);
      rd_chk("prog_dpoll", OP_READ, 21'h00_4010, 8'h5A);
      rd_chk("prog_toggle", OP_READ, 21'h00_4011, 8'h3C);
      run_op(OP_PROG, 21'h00_4010, 8'hFF, 1'b0, 1'b1);
      run_op(OP_PROG, 21'h00_4011, 8'hC3, 1'b1, 1'b1);
      rd_chk("after_fail", OP_READ, 21'h00_4010, 8'h5A);
      rd_chk("query_prot", OP_PROT_QUERY, 21'h00_2000, 8'h01);
      run_op(OP_RESET, 21'h00_0000, 8'h00, 1'b0, 1'b0);
      rd_chk("query_unprot", OP_PROT_QUERY, 21'h00_4000, 8'h00);
      run_op(OP_RESET, 21'h00_0000, 8'h00, 1'b0, 1'b0);
      run_op(OP_PROG, 21'h00_2005, 8'h00, 1'b1, 1'b0);
      rd_chk("prot_prog", OP_READ, 21'h00_2005, 8'hFF);
      run_op(OP_SUSPEND, 21'h00_0000, 8'h00, 1'b0, 1'b0);
      run_op(OP_RESUME, 21'h00_0000, 8'h00, 1'b0, 1'b0);
      rd_chk("no_suspend", OP_READ, 21'h00_4011, 8'h3C);
      start_op(OP_SECT_ERASE, 21'h00_4000, 8'h00, 1'b1);
      repeat (200) @(posedge mclk);
      reg_read(`REG_STAT, stat);
      check("busy_ready", 32'h0000_0001, stat & 32'h0000_0011);
      wait_done(1'b0);
      rd_chk("sect_erase", OP_READ, 21'h00_4010, 8'hFF);
      run_op(OP_PROG, 21'h00_6000, 8'h11, 1'b0, 1'b0);
      run_op(OP_CHIP_ERASE, 21'h00_0000, 8'h00, 1'b0, 1'b0);
      rd_chk("chip_erase", OP_READ, 21'h00_6000, 8'hFF);
      run_op(OP_SECT_ERASE, 21'h00_2000, 8'h00, 1'b0, 1'b0);
      finish_test();
   end
endmodule
